// File: bome_alu.sv
// shared constants and types for the branch/or/move execute block, and its result datapath.
// assumes the instruction decoder hands over an already decoded operation with its fields.
package bome_pkg;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_UNCOND_BRANCH,
    OP_OR_LITERAL,
    OP_INCREMENT_FILE,
    OP_OR_FILE,
    OP_MOVE_FILE,
    OP_STORE_WORKING
  } bome_op_t;

  localparam int DATA_W      = 8;
  localparam int FADDR_W     = 7;
  localparam int LIT_W       = 11;
  localparam int PC_W        = 13;
  localparam int PC_LOW_W    = 11;
  localparam int LATCH_W     = 8;
  localparam int LATCH_LO    = 3;
  localparam int LATCH_HI    = 4;
  localparam int CNT_W       = 2;

  localparam logic             DEST_WORKING = 1'b0;
  localparam logic             DEST_FILE    = 1'b1;
  localparam logic [DATA_W-1:0] WORKING_RST = 8'h00;
  localparam logic             ZERO_RST     = 1'b0;
  localparam logic [PC_W-1:0]  PC_RST       = 13'h0000;
  localparam logic [DATA_W-1:0] DATA_ZERO   = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ONE    = 8'h01;
  localparam logic [CNT_W-1:0] BRANCH_CYCLES = 2'h2;
  localparam logic [CNT_W-1:0] CNT_ONE       = 2'h1;
  localparam logic [CNT_W-1:0] CNT_RST       = 2'h0;

  // zero flag value for an 8-bit result
  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    return (v == DATA_ZERO);
  endfunction

  // true for the operations that carry a destination-select bit
  function automatic logic has_dest(input bome_op_t op);
    return (op == OP_INCREMENT_FILE) || (op == OP_OR_FILE) || (op == OP_MOVE_FILE);
  endfunction

endpackage

module bome_alu (
  input  wire  bome_pkg::bome_op_t          op,        // decoded operation
  input  wire  logic [bome_pkg::DATA_W-1:0] working,   // working register value
  input  wire  logic [bome_pkg::DATA_W-1:0] file_val,  // addressed file register value
  input  wire  logic [bome_pkg::DATA_W-1:0] literal,   // 8-bit literal
  output logic       [bome_pkg::DATA_W-1:0] result,    // operation result
  output logic                              result_z,  // result equals zero
  output logic                              z_update   // operation affects the zero flag
);

  wire logic [bome_pkg::DATA_W-1:0] or_lit_val = working | literal;
  wire logic [bome_pkg::DATA_W-1:0] inc_val    = file_val + bome_pkg::DATA_ONE;
  wire logic [bome_pkg::DATA_W-1:0] or_f_val   = working | file_val;

  always_comb begin
    result   = bome_pkg::DATA_ZERO;
    z_update = 1'b0;
    case (op)
      bome_pkg::OP_OR_LITERAL: begin
        result   = or_lit_val;
        z_update = 1'b1;
      end
      bome_pkg::OP_INCREMENT_FILE: begin
        result   = inc_val;
        z_update = 1'b1;
      end
      bome_pkg::OP_OR_FILE: begin
        result   = or_f_val;
        z_update = 1'b1;
      end
      bome_pkg::OP_MOVE_FILE: begin
        result   = file_val;
        z_update = 1'b1;
      end
      bome_pkg::OP_STORE_WORKING: begin
        result   = working;
        z_update = 1'b0;
      end
      default: begin
        result   = bome_pkg::DATA_ZERO;
        z_update = 1'b0;
      end
    endcase
  end

  assign result_z = bome_pkg::is_zero(result);

endmodule

// File: bome_exec.sv
// execute stage for the unconditional branch, or-literal, or-file, increment-file,
// move-file and store-working operations; owns the working register and zero flag.
// assumes a decoder that presents one decoded operation per cycle with valid/ready,
// and a register file with a combinational read port and a one-cycle write port.
module bome_exec (
  input  wire  logic                              mclk,            // core clock
  input  wire  logic                              reset,           // async reset, active high
  input  wire  logic                              instr_valid,     // decoded operation offered
  input  wire  bome_pkg::bome_op_t                instr_op,        // decoded operation
  input  wire  logic [bome_pkg::LIT_W-1:0]        instr_literal,   // immediate / literal field
  input  wire  logic [bome_pkg::FADDR_W-1:0]      instr_file_addr, // file register address
  input  wire  logic                              instr_dest_sel,  // 0 working, 1 file
  input  wire  logic [bome_pkg::LATCH_W-1:0]      pc_high_latch,   // program counter high latch
  input  wire  logic [bome_pkg::DATA_W-1:0]       file_rd_data,    // register file read data
  output logic                                    instr_ready,     // operation can be taken
  output logic       [bome_pkg::FADDR_W-1:0]      file_rd_addr,    // register file read address
  output logic                                    file_wr_en,      // register file write pulse
  output logic       [bome_pkg::FADDR_W-1:0]      file_wr_addr,    // register file write address
  output logic       [bome_pkg::DATA_W-1:0]       file_wr_data,    // register file write data
  output logic       [bome_pkg::DATA_W-1:0]       working,         // working register
  output logic                                    zero_flag,       // zero status flag
  output logic                                    zero_we,         // zero flag updated pulse
  output logic                                    pc_load,         // program counter load pulse
  output logic       [bome_pkg::PC_W-1:0]         program_counter, // branch target value
  output logic                                    instr_done,      // operation retired pulse
  output logic                                    op_unsupported   // unknown operation pulse
);

  typedef enum logic {
    ST_READY,
    ST_BRANCH_FILL
  } bome_state_t;

  bome_state_t state_q;
  bome_state_t state_d;

  logic [bome_pkg::CNT_W-1:0]   cnt_q;
  logic [bome_pkg::CNT_W-1:0]   cnt_d;
  logic [bome_pkg::DATA_W-1:0]  working_q;
  logic [bome_pkg::DATA_W-1:0]  working_d;
  logic                         zero_q;
  logic                         zero_d;
  logic                         zero_we_q;
  logic                         file_wr_en_q;
  logic [bome_pkg::FADDR_W-1:0] file_wr_addr_q;
  logic [bome_pkg::DATA_W-1:0]  file_wr_data_q;
  logic                         pc_load_q;
  logic [bome_pkg::PC_W-1:0]    pc_q;
  logic [bome_pkg::PC_W-1:0]    pc_d;
  logic                         done_q;
  logic                         done_d;
  logic                         unsup_q;

  logic [bome_pkg::DATA_W-1:0]  alu_result;
  logic                         alu_zero;
  logic                         alu_z_update;

  // handshake and operation decode
  wire logic accept       = instr_valid & instr_ready;
  wire logic op_branch    = (instr_op == bome_pkg::OP_UNCOND_BRANCH);
  wire logic op_or_lit    = (instr_op == bome_pkg::OP_OR_LITERAL);
  wire logic op_store_w   = (instr_op == bome_pkg::OP_STORE_WORKING);
  wire logic op_dest      = bome_pkg::has_dest(instr_op);
  wire logic op_known     = op_branch | op_or_lit | op_store_w | op_dest;
  wire logic dest_is_file = (instr_dest_sel == bome_pkg::DEST_FILE);
  wire logic dest_is_work = (instr_dest_sel == bome_pkg::DEST_WORKING);

  wire logic take_branch  = accept & op_branch;
  wire logic take_single  = accept & op_known & ~op_branch;
  wire logic take_unsup   = accept & ~op_known;

  // destination selection
  wire logic write_file   = accept & ((op_dest & dest_is_file) | op_store_w);
  wire logic write_work   = accept & ((op_dest & dest_is_work) | op_or_lit);
  wire logic write_zero   = accept & alu_z_update;

  // a write still in flight to the address being read is forwarded, since the
  // register file only holds it after the edge that follows
  wire logic fwd_hit = file_wr_en_q & (file_wr_addr_q == instr_file_addr);
  wire logic [bome_pkg::DATA_W-1:0] file_operand = fwd_hit ? file_wr_data_q : file_rd_data;

  // branch target
  wire logic [bome_pkg::PC_LOW_W-1:0] target_low  = instr_literal[bome_pkg::PC_LOW_W-1:0];
  wire logic [1:0]                    target_high =
    pc_high_latch[bome_pkg::LATCH_HI:bome_pkg::LATCH_LO];
  wire logic [bome_pkg::PC_W-1:0]     target      = {target_high, target_low};

  wire logic fill_last = (state_q == ST_BRANCH_FILL) & (cnt_q == bome_pkg::CNT_ONE);

  bome_alu u_alu (
    .op       (instr_op),
    .working  (working_q),
    .file_val (file_operand),
    .literal  (instr_literal[bome_pkg::DATA_W-1:0]),
    .result   (alu_result),
    .result_z (alu_zero),
    .z_update (alu_z_update)
  );

  // sequencing: a branch holds off the next operation for its second cycle
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      ST_READY: begin
        if (take_branch) begin
          state_d = ST_BRANCH_FILL;
          cnt_d   = bome_pkg::BRANCH_CYCLES - bome_pkg::CNT_ONE;
        end
      end
      ST_BRANCH_FILL: begin
        if (cnt_q == bome_pkg::CNT_ONE) begin
          state_d = ST_READY;
          cnt_d   = bome_pkg::CNT_RST;
        end else begin
          cnt_d   = cnt_q - bome_pkg::CNT_ONE;
        end
      end
      default: begin
        state_d = ST_READY;
        cnt_d   = bome_pkg::CNT_RST;
      end
    endcase
  end

  assign instr_ready = (state_q == ST_READY);

  // next values of architectural state
  assign working_d = write_work ? alu_result : working_q;
  assign zero_d    = write_zero ? alu_zero : zero_q;
  assign pc_d      = take_branch ? target : pc_q;
  assign done_d    = take_single | take_unsup | fill_last;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q <= ST_READY;
      cnt_q   <= bome_pkg::CNT_RST;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      working_q <= bome_pkg::WORKING_RST;
      zero_q    <= bome_pkg::ZERO_RST;
      zero_we_q <= 1'b0;
    end else begin
      working_q <= working_d;
      zero_q    <= zero_d;
      zero_we_q <= write_zero;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      file_wr_en_q   <= 1'b0;
      file_wr_addr_q <= {bome_pkg::FADDR_W{1'b0}};
      file_wr_data_q <= bome_pkg::DATA_ZERO;
    end else begin
      file_wr_en_q   <= write_file;
      file_wr_addr_q <= instr_file_addr;
      file_wr_data_q <= alu_result;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pc_load_q <= 1'b0;
      pc_q      <= bome_pkg::PC_RST;
    end else begin
      pc_load_q <= take_branch;
      pc_q      <= pc_d;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      done_q  <= 1'b0;
      unsup_q <= 1'b0;
    end else begin
      done_q  <= done_d;
      unsup_q <= take_unsup;
    end
  end

  assign file_rd_addr    = instr_file_addr;
  assign file_wr_en      = file_wr_en_q;
  assign file_wr_addr    = file_wr_addr_q;
  assign file_wr_data    = file_wr_data_q;
  assign working         = working_q;
  assign zero_flag       = zero_q;
  assign zero_we         = zero_we_q;
  assign pc_load         = pc_load_q;
  assign program_counter = pc_q;
  assign instr_done      = done_q;
  assign op_unsupported  = unsup_q;

endmodule

// File: bome_exec_checker.sv
// concurrent checks on the execute block ports
// assumes bome_pkg is compiled first; bound into every bome_exec
module bome_exec_checker (
  input wire logic               mclk,            // core clock
  input wire logic               reset,           // async reset
  input wire logic               instr_valid,     // op offered
  input wire bome_pkg::bome_op_t instr_op,        // op code
  input wire logic [10:0]        instr_literal,   // immediate
  input wire logic [6:0]         instr_file_addr, // file address
  input wire logic               instr_dest_sel,  // destination
  input wire logic [7:0]         pc_high_latch,   // latch
  input wire logic [7:0]         file_rd_data,    // read data
  input wire logic               instr_ready,     // ready
  input wire logic               file_wr_en,      // write pulse
  input wire logic [6:0]         file_wr_addr,    // write address
  input wire logic [7:0]         file_wr_data,    // write data
  input wire logic [7:0]         working,         // working reg
  input wire logic               zero_flag,       // zero flag
  input wire logic               zero_we,         // zero update
  input wire logic               pc_load,         // counter load
  input wire logic [12:0]        program_counter, // target
  input wire logic               instr_done       // retired
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire take  = instr_valid && instr_ready;
  // forwarded reads are not visible on file_rd_data
  wire nofwd = !(file_wr_en && file_wr_addr == instr_file_addr);
  property p_branch_pc;
    logic [12:0] t;
    (take && instr_op == bome_pkg::OP_UNCOND_BRANCH, t = {pc_high_latch[4:3], instr_literal})
      |=> pc_load && program_counter == t;
  endproperty
  a_branch_pc: assert property (p_branch_pc) else $error("branch target wrong");
  property p_branch_two;
    take && instr_op == bome_pkg::OP_UNCOND_BRANCH |=> !instr_ready && !instr_done ##1 instr_done;
  endproperty
  a_branch_two: assert property (p_branch_two) else $error("branch length wrong");
  property p_branch_flags;
    take && instr_op == bome_pkg::OP_UNCOND_BRANCH |=> (!zero_we && $stable(zero_flag)) [*2];
  endproperty
  a_branch_flags: assert property (p_branch_flags) else $error("branch moved flag");
  property p_orlit;
    logic [7:0] v;
    (take && instr_op == bome_pkg::OP_OR_LITERAL, v = working | instr_literal[7:0])
      |=> working == v && zero_we && zero_flag == (v == 8'h00) && instr_done;
  endproperty
  a_orlit: assert property (p_orlit) else $error("or literal wrong");
  property p_inc;
    logic [7:0] v;
    logic d;
    (take && nofwd && instr_op == bome_pkg::OP_INCREMENT_FILE,
     v = file_rd_data + 8'h01, d = instr_dest_sel) |=> zero_we && zero_flag == (v == 8'h00)
      && file_wr_en == d && (d ? file_wr_data == v : working == v);
  endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");
  property p_orfile;
    logic [7:0] v;
    logic d;
    (take && nofwd && instr_op == bome_pkg::OP_OR_FILE,
     v = working | file_rd_data, d = instr_dest_sel) |=> zero_we && zero_flag == (v == 8'h00)
      && file_wr_en == d && (d ? file_wr_data == v : working == v);
  endproperty
  a_orfile: assert property (p_orfile) else $error("or file wrong");
  property p_move_file_op;
    logic [7:0] v;
    (take && nofwd && instr_op == bome_pkg::OP_MOVE_FILE && instr_dest_sel, v = file_rd_data)
      |=> file_wr_en && file_wr_data == v && zero_we && zero_flag == (v == 8'h00);
  endproperty
  a_move_file_op: assert property (p_move_file_op) else $error("move file wrong");
  property p_store;
    logic [7:0] v;
    logic [6:0] a;
    (take && instr_op == bome_pkg::OP_STORE_WORKING, v = working, a = instr_file_addr)
      |=> file_wr_en && file_wr_data == v && file_wr_addr == a && !zero_we && instr_done;
  endproperty
  a_store: assert property (p_store) else $error("store wrong");
endmodule
bind bome_exec bome_exec_checker i_bome_exec_checker (.*);

// File: bome_exec_tb.sv
// random instruction stream bench for the execute block
// assumes bome_pkg, bome_alu, bome_exec and the checker are compiled first
module bome_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic instr_valid = 1'b0;
  bome_pkg::bome_op_t instr_op = bome_pkg::OP_NONE;
  logic [10:0] instr_literal = 11'h000;
  logic [6:0] instr_file_addr = 7'h00;
  logic instr_dest_sel = 1'b0;
  logic [7:0] pc_high_latch = 8'h00;
  logic [7:0] file_rd_data;
  logic instr_ready, file_wr_en, zero_flag, zero_we, pc_load, instr_done, op_unsupported;
  logic [6:0] file_rd_addr, file_wr_addr;
  logic [7:0] file_wr_data, working, w_m, v;
  logic [12:0] program_counter, pc_m;
  logic z_m;
  logic [7:0] mem [128];
  logic [7:0] mem_m [128];
  logic [38:0] exp_q [$];
  int num_errors = 0;
  int total_checks = 0;
  always #25 mclk = ~mclk;
  bome_exec i_bome_exec (.mclk(mclk), .reset(reset), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_literal(instr_literal), .instr_file_addr(instr_file_addr),
    .instr_dest_sel(instr_dest_sel), .pc_high_latch(pc_high_latch),
    .file_rd_data(file_rd_data), .instr_ready(instr_ready), .file_rd_addr(file_rd_addr),
    .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data),
    .working(working), .zero_flag(zero_flag), .zero_we(zero_we), .pc_load(pc_load),
    .program_counter(program_counter), .instr_done(instr_done),
    .op_unsupported(op_unsupported));
  // register file seen by the block
  assign file_rd_data = mem[file_rd_addr];
  // observed words, laid out like the notes in exp_q; rst_obs packs ready, the pulses and the state in its own layout
  wire [38:0] obs = {file_wr_en, file_wr_en ? {file_wr_addr, file_wr_data} : 15'h0000,
    working, zero_flag, program_counter, op_unsupported};
  wire [38:0] rst_obs = {11'h000, instr_ready, file_wr_en, zero_we, pc_load, instr_done,
    op_unsupported, working, zero_flag, program_counter};
  always @(posedge mclk) if (file_wr_en === 1'b1) mem[file_wr_addr] <= file_wr_data;
  task automatic check(input logic [38:0] seen, input logic [38:0] want);
    total_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // reference result of the op about to be taken
  task automatic model();
    logic [7:0] f;
    logic [7:0] r;
    logic wr;
    f = mem_m[instr_file_addr];
    r = w_m;
    wr = (instr_op == bome_pkg::OP_STORE_WORKING);
    if (instr_op == bome_pkg::OP_UNCOND_BRANCH) pc_m = {pc_high_latch[4:3], instr_literal};
    if (instr_op == bome_pkg::OP_OR_LITERAL) begin
      r = w_m | instr_literal[7:0];
      w_m = r;
      z_m = (r == 8'h00);
    end
    if (bome_pkg::has_dest(instr_op)) begin
      r = (instr_op == bome_pkg::OP_INCREMENT_FILE) ? f + 8'h01 :
          (instr_op == bome_pkg::OP_OR_FILE) ? (w_m | f) : f;
      z_m = (r == 8'h00);
      wr = instr_dest_sel;
      if (!instr_dest_sel) w_m = r;
    end
    if (wr) mem_m[instr_file_addr] = r;
    exp_q.push_back({wr, wr ? {instr_file_addr, r} : 15'h0000, w_m, z_m, pc_m,
      instr_op == bome_pkg::OP_NONE || instr_op > bome_pkg::OP_STORE_WORKING});
  endtask
  always @(negedge mclk) begin
    if (!reset && instr_done === 1'b1) begin
      if (exp_q.size() == 0) check(39'h1, 39'h0);
      else check(obs, exp_q.pop_front());
    end
  end
  initial begin
    #40000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(33207));
    for (int i = 0; i < 128; i++) begin
      v = 8'($urandom);
      mem[i] = (v[7:6] == 2'h0) ? 8'h00 : (v[7:6] == 2'h1) ? 8'hff : v;
      mem_m[i] = mem[i];
    end
    w_m = 8'h00;
    z_m = 1'b0;
    pc_m = 13'h0000;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    // valid often stays up after a branch, so the refused cycle is exercised
    for (int n = 0; n < 600; n++) begin
      @(negedge mclk);
      if (n == 300) begin
        // drain first so no pending file write is lost to the mid-run reset
        instr_valid = 1'b0;
        repeat (3) @(negedge mclk);
        check(39'(exp_q.size()), 39'h0);
        reset = 1'b1;
        repeat (3) @(negedge mclk);
        check(rst_obs, 39'h0008000000);
        w_m = 8'h00;
        z_m = 1'b0;
        pc_m = 13'h0000;
        reset = 1'b0;
      end
      instr_valid = ($urandom_range(0, 7) != 0);
      instr_op = bome_pkg::bome_op_t'($urandom_range(0, 7));
      instr_literal = 11'($urandom);
      if ($urandom_range(0, 3) == 0) instr_literal[7:0] = 8'h00;
      instr_file_addr = 7'($urandom_range(0, 3));
      instr_dest_sel = 1'($urandom);
      pc_high_latch = 8'($urandom);
      if (instr_valid && instr_ready === 1'b1) model();
    end
    @(negedge mclk);
    instr_valid = 1'b0;
    repeat (3) @(negedge mclk);
    check(39'(exp_q.size()), 39'h0);
    tally_and_finish();
  end
endmodule
